// ===== pkg/lsc_pkg.sv
// Constants and types for the lane switch control block.
// Assumes a single lane switch with ports A, B and C.
package lsc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] REG_MASK = 8'h00;
  localparam logic [7:0] REG_PORT_A = 8'h01;
  localparam logic [7:0] REG_PORT_B = 8'h02;
  localparam logic [7:0] REG_PORT_C = 8'h03;
  localparam logic [7:0] REG_ROUTE = 8'h04;
  localparam int MASK_W = 5;
  localparam int PORT_W = 5;
  localparam int ROUTE_W = 2;
  localparam logic [MASK_W-1:0] MASK_RESET = 5'h00;
  localparam logic [PORT_W-1:0] PORT_RESET = 5'h00;
  localparam logic [ROUTE_W-1:0] ROUTE_RESET = 2'h0;
  localparam logic [7:0] PTR_RESET = 8'h00;
  // Field positions
  localparam int MASK_SEL_BIT = 3;
  localparam int MASK_BICAST_BIT = 4;
  localparam int PORT_EMPH_LSB = 0;
  localparam int PORT_BOOST_BIT = 2;
  localparam int PORT_LOOP_BIT = 3;
  localparam int PORT_DIS_BIT = 4;
  localparam int ROUTE_SEL_BIT = 0;
  localparam int ROUTE_BICAST_BIT = 1;
  // Snapshot layout: {route, port C, port B, port A, mask}
  localparam int CFG_W = MASK_W + 3 * PORT_W + ROUTE_W;
  localparam int CFG_PORT_LSB = MASK_W;
  localparam int CFG_ROUTE_LSB = MASK_W + 3 * PORT_W;
  // ----------------------------------------
  // Serial interface
  // ----------------------------------------
  localparam logic [3:0] ADDR_PREFIX = 4'h9;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int STD_SCL_KHZ = 100;
  localparam int FAST_SCL_KHZ = 400;
  localparam int MIN_OVERSAMPLE = 8;
  localparam logic [1:0] PIN_EMPH_LOW = 2'h0;
  localparam logic [1:0] PIN_EMPH_HIGH = 2'h2;
  typedef enum logic [1:0] {
    SRC_IDLE = 2'h0, SRC_IN_A = 2'h1, SRC_IN_B = 2'h2, SRC_IN_C = 2'h3
  } lsc_src_t;
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001, ST_ADDR = 9'h002, ST_ACK_ADDR = 9'h004,
    ST_PTR = 9'h008, ST_ACK_PTR = 9'h010, ST_WDATA = 9'h020,
    ST_ACK_WDATA = 9'h040, ST_RDATA = 9'h080, ST_RACK = 9'h100
  } lsc_state_t;
endpackage : lsc_pkg

// ===== rtl/lsc_lane_switch_control_regs.sv
// Lane switch control: serial register slave, pin sync and routing.
// Assumes SCL/SDA are oversampled by link_clk; pins are asynchronous.

// ----------------------------------------
// Three-stage pin synchroniser
// ----------------------------------------
module lsc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  if (W < 1) begin : g_chk
    $error("lsc_sync width must be positive");
  end
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1, s2, s3;
    always_ff @(posedge clk) begin
      if (rst) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        s1 <= d[i];
        s2 <= s1;
        s3 <= s2;
        // Change counts only once two stages agree
        if (s2 == s3) begin
          q[i] <= s3;
        end
      end
    end
  end
endmodule : lsc_sync

// Function
// [R1] Input C goes to output A, B or both per select and dual-cast.
// [R2] Output C takes input A when select is 0, else B.
// [R3] Without dual-cast the unselected demux output idles.
// [R4] A looped port outputs its own input, overriding select and dual-cast.
// [R5] Single loopback on A or B keeps the routing table for other outputs.
// [R6] Output disable forces idle; only registers can set it.
// [R7] One boost bit per port: 0 low boost, 1 high boost.
// [R8] Emphasis setting 0..3; in pin mode pin 0 maps 0, 1 maps 2.
// [R9] Mode pin low is pin mode; high enables the serial slave.
// [R10] Pin mode takes all controls from pins, registers ignored.
// [R11] Serial mode takes boost and emphasis from port registers only.
// [R12] Serial mode: mask bit 1 uses register, 0 uses pin.
// [R13] Host writes 0x1F to mask for full register switching.
// [R14] Mask: bit4 dual-cast, bit3 select, bits2..0 loopback C,B,A.
// [R15] Port registers: bit4 disable, bit3 loop, bit2 boost, bits1..0 emphasis.
// [R16] Route register: bit0 select, bit1 dual-cast.
// [R17] Serial mode: slave only, SCL input, SDA two-way.
// [R18] Serial link works at standard and fast bus rates.
// [R19] SDA changes only with SCL low, except start and stop.
// [R20] Slave address is 1001 then three address pins, MSB first.
// [R21] Register pointer is kept until reset or rewritten.
// [R22] Configuration reset clears all registers and the pointer.
// [R23] Unused register bits ignore writes and read as zero.
module lsc_lane_switch_control_regs #(
  parameter int LINK_CLK_KHZ = 12500
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic mode_pin,
  input wire logic sel_pin,
  input wire logic bicast_pin,
  input wire logic port_a_loop_enable,
  input wire logic port_b_loop_enable,
  input wire logic port_c_loop_enable,
  input wire logic rx_boost_level_c_pin,
  input wire logic [2:0] tx_emphasis_level_pin,
  input wire logic config_reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output lsc_pkg::lsc_src_t out_a_src,
  output lsc_pkg::lsc_src_t out_b_src,
  output lsc_pkg::lsc_src_t out_c_src,
  output logic [2:0] rx_boost_level,
  output logic [5:0] tx_emphasis_level
);
  // Oversampling must resolve the fastest bus rate
  if (LINK_CLK_KHZ < lsc_pkg::MIN_OVERSAMPLE * lsc_pkg::FAST_SCL_KHZ) begin : g_chk
    $error("link clock too slow for fast-mode oversampling"); // [R18]
  end

  // ----------------------------------------
  // Link domain: reset and pin sync
  // ----------------------------------------
  logic rst_l_meta, rst_l;
  always_ff @(posedge link_clk) begin
    rst_l_meta <= rst;
    rst_l <= rst_l_meta;
  end

  logic [6:0] lk_f;
  lsc_sync #(.W(7)) u_lk_sync (
    .clk(link_clk),
    .rst(rst_l),
    .d({config_reset_n, mode_pin, tx_emphasis_level_pin, scl_in, sda_in}),
    .q(lk_f)
  );
  logic cfg_rst_n_f, mode_l, scl_f, sda_f, scl_d, sda_d;
  logic [2:0] addr_pins;
  assign cfg_rst_n_f = lk_f[6];
  assign mode_l = lk_f[5];
  assign addr_pins = lk_f[4:2];
  assign scl_f = lk_f[1];
  assign sda_f = lk_f[0];
  always_ff @(posedge link_clk) begin
    if (rst_l) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  logic clear_l, scl_rise, scl_fall, start_det, stop_det;
  assign clear_l = rst_l | ~cfg_rst_n_f; // [R22]
  assign scl_rise = scl_f & ~scl_d;
  assign scl_fall = ~scl_f & scl_d;
  assign start_det = scl_f & scl_d & sda_d & ~sda_f; // [R19]
  assign stop_det = scl_f & scl_d & ~sda_d & sda_f; // [R19]

  // ----------------------------------------
  // Serial slave engine
  // ----------------------------------------
  lsc_pkg::lsc_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, ptr_reg, rd_data;
  logic rw_reg, sda_oe_n_reg, addr_match, byte_end, wr_stb, ptr_stb;
  logic [lsc_pkg::MASK_W-1:0] mask_reg;
  logic [2:0][lsc_pkg::PORT_W-1:0] port_cfg_reg;
  logic [lsc_pkg::ROUTE_W-1:0] route_reg;

  assign addr_match = shift_reg[7:1] == {lsc_pkg::ADDR_PREFIX, addr_pins}; // [R20]
  assign byte_end = scl_fall && bit_cnt_reg == lsc_pkg::BYTE_BITS;
  assign wr_stb = byte_end && state_reg == lsc_pkg::ST_WDATA && !start_det && !stop_det;
  assign ptr_stb = byte_end && state_reg == lsc_pkg::ST_PTR && !start_det && !stop_det;

  always_comb begin
    unique case (ptr_reg)
      lsc_pkg::REG_MASK: rd_data = {3'h0, mask_reg}; // [R23]
      lsc_pkg::REG_PORT_A: rd_data = {3'h0, port_cfg_reg[0]};
      lsc_pkg::REG_PORT_B: rd_data = {3'h0, port_cfg_reg[1]};
      lsc_pkg::REG_PORT_C: rd_data = {3'h0, port_cfg_reg[2]};
      lsc_pkg::REG_ROUTE: rd_data = {6'h00, route_reg};
      default: rd_data = 8'h00;
    endcase
  end

  // Outputs change only on SCL falls, so SDA never moves with SCL high
  always_ff @(posedge link_clk) begin
    if (clear_l || !mode_l) begin // [R9] [R17]
      state_reg <= lsc_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      rw_reg <= 1'b0;
      sda_oe_n_reg <= 1'b1;
    end else if (start_det) begin
      state_reg <= lsc_pkg::ST_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_n_reg <= 1'b1;
    end else if (stop_det) begin
      state_reg <= lsc_pkg::ST_IDLE;
      sda_oe_n_reg <= 1'b1;
    end else begin
      unique case (state_reg)
        lsc_pkg::ST_IDLE: begin
        end
        lsc_pkg::ST_ADDR, lsc_pkg::ST_PTR, lsc_pkg::ST_WDATA: begin
          if (scl_rise && bit_cnt_reg != lsc_pkg::BYTE_BITS) begin
            shift_reg <= {shift_reg[6:0], sda_f};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_end) begin
            bit_cnt_reg <= 4'h0;
            sda_oe_n_reg <= 1'b0;
            if (state_reg == lsc_pkg::ST_ADDR) begin
              rw_reg <= shift_reg[0];
              state_reg <= lsc_pkg::ST_ACK_ADDR;
              if (!addr_match) begin // [R20]
                state_reg <= lsc_pkg::ST_IDLE;
                sda_oe_n_reg <= 1'b1;
              end
            end else if (state_reg == lsc_pkg::ST_PTR) begin
              state_reg <= lsc_pkg::ST_ACK_PTR;
            end else begin
              state_reg <= lsc_pkg::ST_ACK_WDATA;
            end
          end
        end
        lsc_pkg::ST_ACK_ADDR: begin
          if (scl_fall && rw_reg) begin
            state_reg <= lsc_pkg::ST_RDATA;
            shift_reg <= rd_data; // [R21]
            sda_oe_n_reg <= rd_data[7];
          end else if (scl_fall) begin
            state_reg <= lsc_pkg::ST_PTR;
            sda_oe_n_reg <= 1'b1;
          end
        end
        lsc_pkg::ST_ACK_PTR, lsc_pkg::ST_ACK_WDATA: begin
          if (scl_fall) begin
            state_reg <= lsc_pkg::ST_WDATA;
            sda_oe_n_reg <= 1'b1;
          end
        end
        lsc_pkg::ST_RDATA: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_end) begin
            state_reg <= lsc_pkg::ST_RACK;
            bit_cnt_reg <= 4'h0;
            sda_oe_n_reg <= 1'b1;
          end else if (scl_fall) begin
            shift_reg <= {shift_reg[6:0], 1'b0};
            sda_oe_n_reg <= shift_reg[6];
          end
        end
        lsc_pkg::ST_RACK: begin
          // No acknowledge ends the read; the bus then waits for stop
          if (scl_rise && sda_f) begin
            state_reg <= lsc_pkg::ST_IDLE;
          end else if (scl_fall) begin
            state_reg <= lsc_pkg::ST_RDATA;
            shift_reg <= rd_data;
            sda_oe_n_reg <= rd_data[7];
          end
        end
      endcase
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe_n = sda_oe_n_reg; // [R17]

  // ----------------------------------------
  // Register file and pointer
  // ----------------------------------------
  always_ff @(posedge link_clk) begin
    if (clear_l) begin
      ptr_reg <= lsc_pkg::PTR_RESET; // [R22]
    end else if (ptr_stb) begin
      ptr_reg <= shift_reg; // [R21]
    end
  end

  always_ff @(posedge link_clk) begin
    if (clear_l) begin // [R22]
      mask_reg <= lsc_pkg::MASK_RESET;
      port_cfg_reg <= {3{lsc_pkg::PORT_RESET}};
      route_reg <= lsc_pkg::ROUTE_RESET;
    end else if (wr_stb) begin
      unique case (ptr_reg)
        lsc_pkg::REG_MASK: mask_reg <= shift_reg[lsc_pkg::MASK_W-1:0]; // [R14] [R23]
        lsc_pkg::REG_PORT_A: port_cfg_reg[0] <= shift_reg[lsc_pkg::PORT_W-1:0]; // [R15]
        lsc_pkg::REG_PORT_B: port_cfg_reg[1] <= shift_reg[lsc_pkg::PORT_W-1:0];
        lsc_pkg::REG_PORT_C: port_cfg_reg[2] <= shift_reg[lsc_pkg::PORT_W-1:0];
        lsc_pkg::REG_ROUTE: route_reg <= shift_reg[lsc_pkg::ROUTE_W-1:0]; // [R16]
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Configuration crossing (toggle handshake)
  // ----------------------------------------
  logic [lsc_pkg::CFG_W-1:0] cfg_l, snap_data_reg, sys_cfg_reg;
  logic snap_req_reg, ack_m, ack_s, req_m, req_s, req_d, sys_ack_reg;
  assign cfg_l = {route_reg, port_cfg_reg, mask_reg};

  always_ff @(posedge link_clk) begin
    if (rst_l) begin
      ack_m <= 1'b0;
      ack_s <= 1'b0;
      snap_req_reg <= 1'b0;
      snap_data_reg <= '0;
    end else begin
      ack_m <= sys_ack_reg;
      ack_s <= ack_m;
      // Data is held stable until the other side has taken it
      if (ack_s == snap_req_reg && cfg_l != snap_data_reg) begin
        snap_data_reg <= cfg_l;
        snap_req_reg <= ~snap_req_reg;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      req_m <= 1'b0;
      req_s <= 1'b0;
      req_d <= 1'b0;
      sys_ack_reg <= 1'b0;
      sys_cfg_reg <= '0;
    end else begin
      req_m <= snap_req_reg;
      req_s <= req_m;
      req_d <= req_s;
      sys_ack_reg <= req_s;
      if (req_s != req_d) begin
        sys_cfg_reg <= snap_data_reg;
      end
    end
  end

  // ----------------------------------------
  // System domain: pins and routing
  // ----------------------------------------
  logic [11:0] ps_f;
  lsc_sync #(.W(12)) u_ps_sync (
    .clk(clk_sys),
    .rst(rst),
    .d({mode_pin, sel_pin, bicast_pin, port_c_loop_enable, port_b_loop_enable,
        port_a_loop_enable, rx_boost_level_c_pin, sda_in, scl_in, tx_emphasis_level_pin}),
    .q(ps_f)
  );
  logic mode_s, eff_sel, eff_bicast;
  logic [2:0] pin_loop, pin_boost, pin_emph, eff_loop, port_dis;
  logic [lsc_pkg::MASK_W-1:0] s_mask;
  logic [lsc_pkg::ROUTE_W-1:0] s_route;
  logic [2:0][lsc_pkg::PORT_W-1:0] s_port;
  lsc_pkg::lsc_src_t route_src [3];
  assign mode_s = ps_f[11];
  assign pin_loop = ps_f[8:6];
  assign pin_boost = ps_f[5:3]; // A on SCL, B on SDA
  assign pin_emph = ps_f[2:0];
  assign s_mask = sys_cfg_reg[lsc_pkg::MASK_W-1:0];
  assign s_port = sys_cfg_reg[lsc_pkg::CFG_PORT_LSB +: 3 * lsc_pkg::PORT_W];
  assign s_route = sys_cfg_reg[lsc_pkg::CFG_ROUTE_LSB +: lsc_pkg::ROUTE_W];
  assign eff_sel = (mode_s && s_mask[lsc_pkg::MASK_SEL_BIT]) ?
                   s_route[lsc_pkg::ROUTE_SEL_BIT] : ps_f[10]; // [R10] [R12]
  assign eff_bicast = (mode_s && s_mask[lsc_pkg::MASK_BICAST_BIT]) ?
                      s_route[lsc_pkg::ROUTE_BICAST_BIT] : ps_f[9]; // [R12]

  // Demux outputs follow the switch table; loops override per port
  always_comb begin
    route_src[0] = eff_loop[0] ? lsc_pkg::SRC_IN_A : // [R4]
                   (eff_bicast || !eff_sel) ? lsc_pkg::SRC_IN_C : lsc_pkg::SRC_IDLE; // [R1] [R3]
    route_src[1] = eff_loop[1] ? lsc_pkg::SRC_IN_B : // [R4]
                   (eff_bicast || eff_sel) ? lsc_pkg::SRC_IN_C : lsc_pkg::SRC_IDLE; // [R5]
    route_src[2] = eff_loop[2] ? lsc_pkg::SRC_IN_C :
                   eff_sel ? lsc_pkg::SRC_IN_B : lsc_pkg::SRC_IN_A; // [R2]
  end

  lsc_pkg::lsc_src_t out_src [3];
  for (genvar i = 0; i < 3; i++) begin : g_port
    assign eff_loop[i] = (mode_s && s_mask[i]) ?
                         s_port[i][lsc_pkg::PORT_LOOP_BIT] : pin_loop[i]; // [R12] [R14]
    assign port_dis[i] = mode_s && s_port[i][lsc_pkg::PORT_DIS_BIT]; // [R6]
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        out_src[i] <= lsc_pkg::SRC_IDLE;
        rx_boost_level[i] <= 1'b0;
        tx_emphasis_level[2*i +: 2] <= lsc_pkg::PIN_EMPH_LOW;
      end else begin
        out_src[i] <= port_dis[i] ? lsc_pkg::SRC_IDLE : route_src[i]; // [R6]
        if (mode_s) begin // [R11]
          rx_boost_level[i] <= s_port[i][lsc_pkg::PORT_BOOST_BIT]; // [R7]
          tx_emphasis_level[2*i +: 2] <= s_port[i][lsc_pkg::PORT_EMPH_LSB +: 2]; // [R8]
        end else begin // [R10]
          rx_boost_level[i] <= pin_boost[i];
          tx_emphasis_level[2*i +: 2] <= pin_emph[i] ?
                                         lsc_pkg::PIN_EMPH_HIGH : lsc_pkg::PIN_EMPH_LOW; // [R8]
        end
      end
    end
  end
  assign out_a_src = out_src[0];
  assign out_b_src = out_src[1];
  assign out_c_src = out_src[2];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_LOOP_A_OWN: assert property (@(posedge clk_sys) disable iff (rst) // [R4]
    eff_loop[0] && !port_dis[0] |=> out_a_src == lsc_pkg::SRC_IN_A)
    else $error("looped port A not carrying its own input");
  AST_MUX_SEL: assert property (@(posedge clk_sys) disable iff (rst) // [R2]
    !eff_loop[2] && !port_dis[2] |=> out_c_src == ($past(eff_sel) ?
    lsc_pkg::SRC_IN_B : lsc_pkg::SRC_IN_A))
    else $error("output C source does not follow select");
  AST_IDLE_UNSEL: assert property (@(posedge clk_sys) disable iff (rst) // [R3]
    eff_sel && !eff_bicast && !eff_loop[0] |=> out_a_src == lsc_pkg::SRC_IDLE)
    else $error("unselected output A not idle");
  AST_BICAST: assert property (@(posedge clk_sys) disable iff (rst) // [R1]
    eff_bicast && eff_loop[1:0] == 2'h0 && port_dis[1:0] == 2'h0 |=>
    out_a_src == lsc_pkg::SRC_IN_C && out_b_src == lsc_pkg::SRC_IN_C)
    else $error("dual-cast not sending input C to both outputs");
  AST_DISABLE: assert property (@(posedge clk_sys) disable iff (rst) // [R6]
    mode_s && s_port[1][lsc_pkg::PORT_DIS_BIT] |=> out_b_src == lsc_pkg::SRC_IDLE)
    else $error("disabled output B not idle");
  AST_PIN_EMPH: assert property (@(posedge clk_sys) disable iff (rst) // [R8]
    !mode_s |=> tx_emphasis_level[1:0] == ($past(pin_emph[0]) ? 2'h2 : 2'h0))
    else $error("pin mode emphasis mapping wrong");
  AST_REG_BOOST: assert property (@(posedge clk_sys) disable iff (rst) // [R11]
    mode_s |=> rx_boost_level[2] == $past(s_port[2][lsc_pkg::PORT_BOOST_BIT]))
    else $error("serial mode boost not from register");
  AST_MASK_PIN: assert property (@(posedge clk_sys) disable iff (rst) // [R12]
    (mode_s && !s_mask[lsc_pkg::MASK_SEL_BIT]) || !mode_s |-> eff_sel == ps_f[10])
    else $error("select not taken from pin");
  AST_CFG_CLEAR: assert property (@(posedge link_clk) disable iff (rst_l) // [R22]
    !cfg_rst_n_f |=> mask_reg == '0 && route_reg == '0 && port_cfg_reg == '0 && ptr_reg == '0)
    else $error("configuration reset did not clear registers");
  AST_SDA_SCL_LOW: assert property (@(posedge link_clk) disable iff (rst_l) // [R19]
    $past(!mode_l || clear_l || start_det || stop_det) || $stable(sda_oe_n_reg) || !$past(scl_f))
    else $error("SDA moved while SCL high");
  AST_ADDR_ACK: assert property (@(posedge link_clk) disable iff (rst_l) // [R20]
    state_reg == lsc_pkg::ST_ACK_ADDR |-> addr_match)
    else $error("acknowledged a foreign address");
  AST_PIN_MODE_QUIET: assert property (@(posedge link_clk) disable iff (rst_l) // [R9]
    !mode_l |=> state_reg == lsc_pkg::ST_IDLE && sda_oe_n_reg)
    else $error("serial slave active in pin mode");
  COV_BICAST: cover property (@(posedge clk_sys) disable iff (rst)
    out_a_src == lsc_pkg::SRC_IN_C && out_b_src == lsc_pkg::SRC_IN_C);
  COV_LOOP_C: cover property (@(posedge clk_sys) disable iff (rst)
    out_c_src == lsc_pkg::SRC_IN_C);
  COV_WRITE: cover property (@(posedge link_clk) disable iff (rst_l) wr_stb);
  COV_READ: cover property (@(posedge link_clk) disable iff (rst_l)
    state_reg == lsc_pkg::ST_RACK);
endmodule : lsc_lane_switch_control_regs

// ===== tb/lsc_i2c_master.sv
// Serial bus master model for the lane switch control wires.
// Assumes the bench resolves SDA as open drain with a pull-up.
module lsc_i2c_master (
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Bus phases
  // ----------------------------------------
  int h = 1250; // Half SCL period, 1250 fast or 5000 standard
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Data moves mid-low, clear of the slave's SCL rise sampling
  task automatic bit_io(input logic b, output logic r);
    #(h / 2) sda_drv = b;
    #(h / 2) scl = 1'b1;
    #(h) r = sda;
    scl = 1'b0;
  endtask : bit_io
  // Start or repeated start: SDA falls with SCL high
  task automatic start();
    #(h / 2) sda_drv = 1'b1;
    #(h / 2) scl = 1'b1;
    #(h) sda_drv = 1'b0;
    #(h) scl = 1'b0;
  endtask : start
  task automatic stop();
    #(h / 2) sda_drv = 1'b0;
    #(h / 2) scl = 1'b1;
    #(h) sda_drv = 1'b1;
    #(h);
  endtask : stop
  task automatic send_byte(input logic [7:0] d, output logic ack_n);
    for (int i = 7; i >= 0; i--) bit_io(d[i], ack_n);
    bit_io(1'b1, ack_n);
  endtask : send_byte
  task automatic recv_byte(output logic [7:0] d, input logic nack);
    logic x;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, x);
  endtask : recv_byte
endmodule : lsc_i2c_master

// ===== tb/test_lane_switch_control_regs.sv
// Self-checking bench for the lane switch control block.
// Assumes the design package is compiled first; serial master in its own file.
module test_lane_switch_control_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic link_clk = 1'b0;
  logic rst, mode_pin, cpin, cfg_n, sda_out, sda_oe_n;
  logic [4:0] sw_pins;
  logic [2:0] ep, adr, boost;
  logic [5:0] emph;
  logic [6:0] dev;
  logic [7:0] rg [5];
  logic [31:0] seed = 32'hb596;
  logic [31:0] r;
  wire logic scl_m, sda_m, sda_w;
  lsc_pkg::lsc_src_t oa, ob, oc;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  // Open drain: either party pulls low, pull-up otherwise
  assign sda_w = sda_m & (sda_oe_n | sda_out);
  always #50 clk_sys = ~clk_sys;
  initial begin
    #13;
    forever #40 link_clk = ~link_clk;
  end
  lsc_i2c_master m (.scl(scl_m), .sda_drv(sda_m), .sda(sda_w));
  lsc_lane_switch_control_regs #(.LINK_CLK_KHZ(12500)) dut (
    .clk_sys(clk_sys), .rst(rst), .link_clk(link_clk), .mode_pin(mode_pin),
    .sel_pin(sw_pins[3]), .bicast_pin(sw_pins[4]), .port_a_loop_enable(sw_pins[0]),
    .port_b_loop_enable(sw_pins[1]), .port_c_loop_enable(sw_pins[2]),
    .rx_boost_level_c_pin(cpin), .tx_emphasis_level_pin(ep), .config_reset_n(cfg_n),
    .scl_in(scl_m), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .out_a_src(oa), .out_b_src(ob), .out_c_src(oc), .rx_boost_level(boost),
    .tx_emphasis_level(emph));
  // ----------------------------------------
  // Reference model and checks
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [14:0] model();
    logic [4:0] rv, c;
    logic [1:0] a, b, o;
    rv = {rg[4][1:0], rg[3][3], rg[2][3], rg[1][3]};
    c = mode_pin ? ((rg[0][4:0] & rv) | (~rg[0][4:0] & sw_pins)) : sw_pins;
    a = c[0] ? 2'h1 : (c[4] | ~c[3]) ? 2'h3 : 2'h0;
    b = c[1] ? 2'h2 : (c[4] | c[3]) ? 2'h3 : 2'h0;
    o = c[2] ? 2'h3 : c[3] ? 2'h2 : 2'h1;
    if (!mode_pin) return {a, b, o, cpin, sda_w, scl_m, ep[2], 1'b0, ep[1], 1'b0, ep[0], 1'b0};
    return {rg[1][4] ? 2'h0 : a, rg[2][4] ? 2'h0 : b, rg[3][4] ? 2'h0 : o,
      rg[3][2], rg[2][2], rg[1][2], rg[3][1:0], rg[2][1:0], rg[1][1:0]};
  endfunction : model
  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic settle_check();
    repeat (20) @(posedge clk_sys);
    check({oa, ob, oc, boost, emph}, model());
  endtask : settle_check
  task automatic wr(input logic [6:0] d7, input logic [7:0] p, input logic [7:0] d,
                    input logic e);
    logic a0, a1, a2;
    m.start();
    m.send_byte({d7, 1'b0}, a0);
    m.send_byte(p, a1);
    m.send_byte(d, a2);
    m.stop();
    check(15'({a0, a1, a2}), 15'({3{e}}));
    if (!e && p < 8'h05) rg[p] = d & ((p == 8'h04) ? 8'h03 : 8'h1f);
  endtask : wr
  task automatic rd(input logic [7:0] p, input logic setp);
    logic a0, a1, a2;
    logic [7:0] d, d0, x;
    a0 = 1'b0;
    a1 = 1'b0;
    // Unmapped pointers read as zero
    x = (p < 8'h05) ? rg[p] : 8'h00;
    if (setp) begin
      m.start();
      m.send_byte({dev, 1'b0}, a0);
      m.send_byte(p, a1);
    end
    m.start();
    m.send_byte({dev, 1'b1}, a2);
    m.recv_byte(d0, 1'b0);
    m.recv_byte(d, 1'b1);
    m.stop();
    check(15'({a0, a1, a2}), 15'h0000);
    check(15'(d0), 15'(x));
    check(15'(d), 15'(x));
  endtask : rd
  task automatic report_and_stop();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  // Whole run needs about 60k cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    cfg_n = 1'b1;
    cpin = 1'b0;
    sw_pins = 5'h00;
    r = rnd();
    adr = r[2:0];
    dev = {4'h9, adr};
    ep = adr;
    mode_pin = 1'b1;
    foreach (rg[i]) rg[i] = 8'h00;
    // Two-flop crossing stretches it over the link domain
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    settle_check();
    for (int p = 0; p < 5; p++) rd(p[7:0], 1'b1);
    wr({4'h9, adr ^ 3'h1}, 8'h00, 8'h1f, 1'b1);
    wr(dev, 8'h07, 8'hff, 1'b0);
    rd(8'h07, 1'b1);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      @(posedge clk_sys);
      sw_pins <= r[4:0];
      m.h = (i == 2) ? 5000 : 1250;
      wr(dev, 8'h00, (i == 0) ? 8'h1f : (i == 1) ? 8'h0c : r[12:5], 1'b0);
      for (int p = 1; p < 5; p++) begin
        r = rnd();
        wr(dev, p[7:0], r[7:0], 1'b0);
      end
      settle_check();
    end
    for (int p = 0; p < 5; p++) rd(p[7:0], 1'b1);
    rd(8'h04, 1'b0);
    @(posedge clk_sys);
    mode_pin <= 1'b0;
    wr(dev, 8'h01, 8'h1f, 1'b1);
    for (int i = 0; i < 32; i++) begin
      r = rnd();
      @(posedge clk_sys);
      sw_pins <= i[4:0];
      cpin <= r[0];
      ep <= r[3:1];
      m.scl <= r[4];
      m.sda_drv <= r[5];
      settle_check();
    end
    @(posedge clk_sys);
    m.scl <= 1'b1;
    m.sda_drv <= 1'b1;
    ep <= adr;
    mode_pin <= 1'b1;
    settle_check();
    @(posedge clk_sys);
    cfg_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    cfg_n <= 1'b1;
    foreach (rg[i]) rg[i] = 8'h00;
    settle_check();
    rd(8'h00, 1'b0);
    report_and_stop();
  end
endmodule : test_lane_switch_control_regs
